//--- logic/embedded_ram_tile.sv
// Embedded RAM tile with two ports, lane-masked writes and selectable register clocking.
`timescale 1ns/1ns
module embedded_ram_tile (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] cfg_ram_mode,
  input wire logic [1:0] cfg_clock_mode,
  input wire logic [3:0] cfg_width_a,
  input wire logic [3:0] cfg_width_b,
  input wire logic cfg_bypass_a,
  input wire logic cfg_bypass_b,
  input wire logic tick_a,
  input wire logic tick_b,
  input wire logic ce_a,
  input wire logic ce_b,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire logic [embedded_ram_tile_pkg::ADDR_W-1:0] addr_a,
  input wire logic [embedded_ram_tile_pkg::DATA_W-1:0] din_a,
  input wire logic [embedded_ram_tile_pkg::LANES-1:0] be_a,
  input wire logic we_a,
  input wire logic re_a,
  input wire logic [embedded_ram_tile_pkg::ADDR_W-1:0] addr_b,
  input wire logic [embedded_ram_tile_pkg::DATA_W-1:0] din_b,
  input wire logic [embedded_ram_tile_pkg::LANES-1:0] be_b,
  input wire logic we_b,
  input wire logic re_b,
  output logic [embedded_ram_tile_pkg::DATA_W-1:0] dout_a,
  output logic [embedded_ram_tile_pkg::DATA_W-1:0] dout_b,
  output logic config_error
);

  embedded_ram_tile_pkg::tile_state_t s_reg;
  embedded_ram_tile_pkg::tile_state_t s_next;

  embedded_ram_tile_pkg::ram_mode_t ram_mode;
  embedded_ram_tile_pkg::clock_mode_t clock_mode;
  embedded_ram_tile_pkg::width_t width [2];
  embedded_ram_tile_pkg::wr_map_t wmap [2];

  logic [1:0] tick;
  logic [1:0] ce;
  logic [1:0] clr;
  logic [1:0] bypass;
  logic [1:0] in_sel;
  logic [1:0] out_sel;
  logic [1:0] wr_allow;
  logic [1:0][embedded_ram_tile_pkg::ADDR_W-1:0] addr_in;
  logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] din_in;
  logic [1:0][embedded_ram_tile_pkg::LANES-1:0] be_in;
  logic [1:0] we_in;
  logic [1:0] re_in;
  logic cfg_err;
  logic simple_dual;

  logic [1:0] arr_rd;
  logic [1:0] arr_wr;
  logic [1:0][embedded_ram_tile_pkg::ROW_W-1:0] arr_row;
  logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] arr_wdata;
  logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] arr_mask;
  logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] arr_rdata;

  // Index 0 is clock A and port A, index 1 is clock B and port B.
  assign tick = {tick_b, tick_a};
  assign ce = {ce_b, ce_a};
  assign clr = {clr_b, clr_a};
  assign bypass = {cfg_bypass_b, cfg_bypass_a};
  assign addr_in = {addr_b, addr_a};
  assign din_in = {din_b, din_a};
  assign be_in = {be_b, be_a};
  assign we_in = {we_b, we_a};
  assign re_in = {re_b, re_a};

  assign ram_mode = embedded_ram_tile_pkg::ram_mode_t'(cfg_ram_mode);
  assign clock_mode = embedded_ram_tile_pkg::clock_mode_t'(cfg_clock_mode);
  assign width[0] = embedded_ram_tile_pkg::width_t'(cfg_width_a);
  assign width[1] = embedded_ram_tile_pkg::width_t'(cfg_width_b);
  assign simple_dual = (ram_mode == embedded_ram_tile_pkg::ram_simple_dual);

  // An illegal mix of modes and widths blocks every access rather than corrupting data.
  assign cfg_err = !embedded_ram_tile_pkg::config_ok(ram_mode, clock_mode, width[0], width[1]);

  // Each register group follows one of the two tile clocks. Input registers of a port
  // always follow that port's clock; the output register follows the other clock only
  // in input/output mode. In read/write mode port A is the write side on clock A and
  // port B the read side on clock B.
  always_comb begin
    in_sel = embedded_ram_tile_pkg::IN_CLK_SEL;
    if (clock_mode == embedded_ram_tile_pkg::clk_in_out) begin
      out_sel = embedded_ram_tile_pkg::OUT_CLK_SEL_SWAP;
    end else begin
      out_sel = embedded_ram_tile_pkg::OUT_CLK_SEL_SAME;
    end
  end

  // In simple dual-port use port B only reads.
  assign wr_allow = simple_dual ? 2'h1 : 2'h3;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      wmap[p] = embedded_ram_tile_pkg::map_write(width[p], s_reg.addr[p], s_reg.din[p], s_reg.be[p]);
      arr_row[p] = wmap[p].row;
      if (ram_mode == embedded_ram_tile_pkg::ram_single_port) begin
        // Each single-port RAM owns one half of the rows, so neither exceeds 2K bits.
        arr_row[p] = {p[0], wmap[p].row[embedded_ram_tile_pkg::ROW_W-2:0]};
      end
      arr_wdata[p] = wmap[p].data;
      arr_mask[p] = wmap[p].mask;
      arr_wr[p] = s_reg.go[p] & s_reg.we[p] & wr_allow[p];
      arr_rd[p] = s_reg.go[p] & s_reg.re[p];
    end
  end

  embedded_ram_tile_array u_array (
    .clk_sys(clk_sys),
    .rst(rst),
    .rd(arr_rd),
    .wr(arr_wr),
    .row(arr_row),
    .wdata(arr_wdata),
    .mask(arr_mask),
    .rdata(arr_rdata)
  );

  always_comb begin
    s_next = s_reg;
    s_next.cfg_err = cfg_err;
    for (int p = 0; p < 2; p++) begin
      s_next.go[p] = 1'b0;
      s_next.rvalid[p] = s_reg.go[p] & s_reg.re[p];
      if (s_reg.go[p]) begin
        s_next.raddr[p] = s_reg.addr[p];
      end
      if (s_reg.rvalid[p]) begin
        s_next.rd_hold[p] = embedded_ram_tile_pkg::extract(width[p], s_reg.raddr[p], arr_rdata[p]);
      end
      // Input registers are never bypassed; all five are loaded on the same edge.
      if (clr[in_sel[p]]) begin
        s_next.addr[p] = '0;
        s_next.din[p] = '0;
        s_next.be[p] = '0;
        s_next.we[p] = 1'b0;
        if (!simple_dual) begin
          s_next.re[p] = 1'b0;
        end
      end else if (tick[in_sel[p]] && ce[in_sel[p]]) begin
        s_next.addr[p] = addr_in[p];
        s_next.din[p] = din_in[p];
        s_next.be[p] = be_in[p];
        s_next.we[p] = we_in[p];
        s_next.re[p] = re_in[p];
        s_next.go[p] = !cfg_err;
      end
      // The output side has its own clear and enable, taken from its own clock.
      if (clr[out_sel[p]]) begin
        s_next.dout[p] = '0;
      end else if (bypass[p]) begin
        if (s_reg.rvalid[p]) begin
          s_next.dout[p] = embedded_ram_tile_pkg::extract(width[p], s_reg.raddr[p], arr_rdata[p]);
        end
      end else if (tick[out_sel[p]] && ce[out_sel[p]]) begin
        s_next.dout[p] = s_reg.rd_hold[p];
      end
    end
    if (rst) begin
      s_next = embedded_ram_tile_pkg::TILE_STATE_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_reg <= s_next;
  end

  assign dout_a = s_reg.dout[0];
  assign dout_b = s_reg.dout[1];
  assign config_error = s_reg.cfg_err;

endmodule

//--- logic/embedded_ram_tile_array.sv
// Storage array of the RAM tile: two ports, bit-masked writes, registered reads.
`timescale 1ns/1ns
module embedded_ram_tile_array (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] rd,
  input wire logic [1:0] wr,
  input wire logic [1:0][embedded_ram_tile_pkg::ROW_W-1:0] row,
  input wire logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] wdata,
  input wire logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] mask,
  output logic [1:0][embedded_ram_tile_pkg::DATA_W-1:0] rdata
);

  embedded_ram_tile_pkg::array_state_t s_reg;
  embedded_ram_tile_pkg::array_state_t s_next;

  // Reads return the row as it stood before a write on the same edge.
  // Port B is applied last, so it wins a collision on the same bits.
  always_comb begin
    s_next = s_reg;
    for (int p = 0; p < 2; p++) begin
      if (rd[p]) begin
        s_next.rdata[p] = s_reg.mem[row[p]];
      end
      if (wr[p]) begin
        s_next.mem[row[p]] = (s_next.mem[row[p]] & ~mask[p]) | (wdata[p] & mask[p]);
      end
    end
    if (rst) begin
      s_next.rdata = embedded_ram_tile_pkg::RDATA_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_reg <= s_next;
  end

  assign rdata = s_reg.rdata;

endmodule

//--- logic/embedded_ram_tile_pkg.sv
// Shared constants, types and mapping functions of the embedded RAM tile.
package embedded_ram_tile_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 36;
  localparam int ROW_W = 7;
  localparam int ROWS = 128;
  localparam int LANES = 4;
  localparam int BYTE_BITS = 8;
  localparam int LANE_BITS = 9;

  typedef enum logic [3:0] {
    width_x1 = 4'h0,
    width_x2 = 4'h1,
    width_x4 = 4'h2,
    width_x8 = 4'h3,
    width_x16 = 4'h4,
    width_x32 = 4'h5,
    width_x9 = 4'h6,
    width_x18 = 4'h7,
    width_x36 = 4'h8
  } width_t;

  typedef enum logic [1:0] {
    ram_true_dual = 2'h0,
    ram_simple_dual = 2'h1,
    ram_single_port = 2'h2
  } ram_mode_t;

  typedef enum logic [1:0] {
    clk_independent = 2'h0,
    clk_in_out = 2'h1,
    clk_read_write = 2'h2
  } clock_mode_t;

  typedef struct packed {
    logic [1:0][ADDR_W-1:0] addr;
    logic [1:0][DATA_W-1:0] din;
    logic [1:0][LANES-1:0] be;
    logic [1:0] we;
    logic [1:0] re;
    logic [1:0] go;
    logic [1:0] rvalid;
    logic [1:0][ADDR_W-1:0] raddr;
    logic [1:0][DATA_W-1:0] rd_hold;
    logic [1:0][DATA_W-1:0] dout;
    logic cfg_err;
  } tile_state_t;

  typedef struct packed {
    logic [ROWS-1:0][DATA_W-1:0] mem;
    logic [1:0][DATA_W-1:0] rdata;
  } array_state_t;

  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] mask;
  } wr_map_t;

  localparam tile_state_t TILE_STATE_RST = '0;
  localparam logic [1:0][DATA_W-1:0] RDATA_RST = '0;
  // Clock index of each port's input registers: port A on clock A, port B on clock B.
  localparam logic [1:0] IN_CLK_SEL = 2'h2;
  localparam logic [1:0] OUT_CLK_SEL_SAME = 2'h2;
  localparam logic [1:0] OUT_CLK_SEL_SWAP = 2'h1;

  function automatic int unsigned width_bits(width_t w);
    unique case (w)
      width_x1: return 1;
      width_x2: return 2;
      width_x4: return 4;
      width_x8: return 8;
      width_x16: return 16;
      width_x32: return 32;
      width_x9: return 9;
      width_x18: return 18;
      width_x36: return 36;
      default: return 0;
    endcase
  endfunction

  // Log2 of the number of words that share one physical row.
  function automatic int unsigned word_shift(width_t w);
    unique case (w)
      width_x1: return 5;
      width_x2: return 4;
      width_x4: return 3;
      width_x8, width_x9: return 2;
      width_x16, width_x18: return 1;
      default: return 0;
    endcase
  endfunction

  function automatic logic is_parity(width_t w);
    return (w == width_x9) || (w == width_x18) || (w == width_x36);
  endfunction

  function automatic logic lane_mask_ok(width_t w);
    return (w == width_x16) || (w == width_x18) || (w == width_x32) || (w == width_x36);
  endfunction

  // Plain data uses eight bits of every nine-bit lane; the ninth is left idle.
  function automatic int unsigned phys_index(int unsigned i, logic par);
    return par ? i : (i / BYTE_BITS) * LANE_BITS + (i % BYTE_BITS);
  endfunction

  function automatic int unsigned word_slot(width_t w, logic [ADDR_W-1:0] addr);
    return 32'(addr) % (32'd1 << word_shift(w));
  endfunction

  function automatic logic [ROW_W-1:0] row_of(width_t w, logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] r;
    r = addr >> word_shift(w);
    return r[ROW_W-1:0];
  endfunction

  function automatic wr_map_t map_write(width_t w, logic [ADDR_W-1:0] addr, logic [DATA_W-1:0] din,
                                        logic [LANES-1:0] be);
    wr_map_t m;
    int unsigned wb;
    int unsigned slot;
    int unsigned p;
    int unsigned lane;
    wb = width_bits(w);
    slot = word_slot(w, addr);
    m.row = row_of(w, addr);
    m.data = '0;
    m.mask = '0;
    for (int j = 0; j < DATA_W; j++) begin
      if (j < wb) begin
        p = phys_index(slot * wb + j, is_parity(w));
        lane = is_parity(w) ? j / LANE_BITS : j / BYTE_BITS;
        m.data[p] = din[j];
        m.mask[p] = lane_mask_ok(w) ? be[lane] : 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] extract(width_t w, logic [ADDR_W-1:0] addr, logic [DATA_W-1:0] row);
    logic [DATA_W-1:0] d;
    int unsigned wb;
    int unsigned slot;
    wb = width_bits(w);
    slot = word_slot(w, addr);
    d = '0;
    for (int j = 0; j < DATA_W; j++) begin
      if (j < wb) begin
        d[j] = row[phys_index(slot * wb + j, is_parity(w))];
      end
    end
    return d;
  endfunction

  function automatic logic config_ok(ram_mode_t rm, clock_mode_t cm, width_t wa, width_t wb);
    logic ok;
    ok = (width_bits(wa) != 0) && (width_bits(wb) != 0) && (is_parity(wa) == is_parity(wb));
    unique case (rm)
      ram_true_dual: begin
        ok = ok && (cm != clk_read_write);
        ok = ok && (wa != width_x32) && (wa != width_x36) && (wb != width_x32) && (wb != width_x36);
      end
      ram_simple_dual: ok = ok && (cm != clk_independent);
      ram_single_port: ok = ok && (cm == clk_independent) && !is_parity(wa) && !is_parity(wb);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

//--- verification/embedded_ram_tile_chk.sv
// Concurrent checks on the RAM tile's outputs and configuration flag.
`timescale 1ns/1ns
module embedded_ram_tile_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] cfg_ram_mode,
  input wire logic [1:0] cfg_clock_mode,
  input wire logic [3:0] cfg_width_a,
  input wire logic [3:0] cfg_width_b,
  input wire logic cfg_bypass_a,
  input wire logic cfg_bypass_b,
  input wire logic ce_a,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire logic [embedded_ram_tile_pkg::DATA_W-1:0] dout_a,
  input wire logic [embedded_ram_tile_pkg::DATA_W-1:0] dout_b,
  input wire logic config_error
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !config_error && dout_a == '0 && dout_b == '0)
    else $error("outputs not cleared by reset");
  wide_dual_a: assert property (cfg_ram_mode == 2'h0 && cfg_width_a == 4'h8 |=> config_error)
    else $error("wide true dual port not flagged");
  single_parity_a: assert property (cfg_ram_mode == 2'h2 && cfg_width_b == 4'h6 |=> config_error)
    else $error("parity width in single port not flagged");
  legal_clean_a: assert property (cfg_ram_mode == 2'h0 && cfg_clock_mode == 2'h0 && cfg_width_a == 4'h4
    && cfg_width_b == 4'h4 |=> !config_error) else $error("legal configuration flagged");
  ce_hold_a: assert property (cfg_clock_mode == 2'h0 && !cfg_bypass_a && !ce_a && !clr_a |=> $stable(dout_a))
    else $error("output moved with clock enable low");
  own_clear_a: assert property (cfg_clock_mode == 2'h0 && !cfg_bypass_a && clr_a |=> dout_a == '0)
    else $error("port clear did not zero its output");
  swap_clear_b_a: assert property (cfg_clock_mode == 2'h1 && !cfg_bypass_a && clr_b |=> dout_a == '0)
    else $error("output clock clear missed port A output");
  swap_clear_a_a: assert property (cfg_clock_mode == 2'h1 && !cfg_bypass_b && clr_a |=> dout_b == '0)
    else $error("output clock clear missed port B output");
  read_clear_a: assert property (cfg_clock_mode == 2'h2 && !cfg_bypass_b && clr_b |=> dout_b == '0)
    else $error("read side clear did not zero output");
endmodule
bind embedded_ram_tile embedded_ram_tile_chk chk (.clk_sys(clk_sys), .rst(rst), .cfg_ram_mode(cfg_ram_mode),
  .cfg_clock_mode(cfg_clock_mode), .cfg_width_a(cfg_width_a), .cfg_width_b(cfg_width_b),
  .cfg_bypass_a(cfg_bypass_a), .cfg_bypass_b(cfg_bypass_b), .ce_a(ce_a), .clr_a(clr_a), .clr_b(clr_b),
  .dout_a(dout_a), .dout_b(dout_b), .config_error(config_error));

//--- verification/ram_user_port.sv
// User-logic model that presents one port's requests to the RAM tile.
`timescale 1ns/1ns
module ram_user_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req,
  input wire logic req_we,
  input wire logic hold,
  input wire logic [embedded_ram_tile_pkg::ADDR_W-1:0] req_addr,
  input wire logic [embedded_ram_tile_pkg::DATA_W-1:0] req_din,
  input wire logic [3:0] req_be,
  output logic tick,
  output logic ce,
  output logic [embedded_ram_tile_pkg::ADDR_W-1:0] addr,
  output logic [embedded_ram_tile_pkg::DATA_W-1:0] din,
  output logic [3:0] be,
  output logic we,
  output logic re
);
  initial {tick, ce, addr, din, be, we, re} = '0;
  // Idle fields flip every cycle so the tile can never lean on a stale value.
  always @(posedge clk_sys) begin
    tick <= !rst;
    ce <= !rst && !hold;
    we <= req && req_we;
    re <= req && !req_we;
    addr <= req ? req_addr : ~addr;
    din <= req ? req_din : ~din;
    be <= req ? req_be : ~be;
  end
endmodule

//--- verification/test_embedded_ram_tile.sv
// Testbench for the RAM tile: lane masks, clock modes, clears and configuration checks.
`timescale 1ns/1ns
module test_embedded_ram_tile;
  typedef logic [embedded_ram_tile_pkg::DATA_W-1:0] word_t;
  localparam word_t BASE = 36'hAAAAAAAAA;
  localparam word_t NEW = 36'h5C3E1F0B7;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cfg_ram_mode = 2'h0;
  logic [1:0] cfg_clock_mode = 2'h0;
  logic [3:0] cfg_width = 4'h4;
  logic [1:0] bypass = 2'h0;
  logic [1:0] clr = 2'h0;
  logic [1:0] req = 2'h0;
  logic [1:0] req_we = 2'h0;
  logic [1:0] hold = 2'h0;
  logic [embedded_ram_tile_pkg::ADDR_W-1:0] req_addr [2] = '{default: '0};
  word_t req_din [2] = '{default: '0};
  logic [3:0] req_be [2] = '{default: '0};
  logic [1:0] tick, ce, we, re;
  logic [embedded_ram_tile_pkg::ADDR_W-1:0] addr [2];
  word_t din [2];
  word_t dout [2];
  logic [3:0] be [2];
  logic config_error;
  int bad_count = 0;
  int total_checks = 0;
  // Widths x36, x32, x18, x16, x8; lane size 0 means the mask is ignored.
  logic [3:0] wt [5] = '{4'h8, 4'h5, 4'h7, 4'h4, 4'h3};
  int wbits [5] = '{36, 32, 18, 16, 8};
  int lbits [5] = '{9, 8, 9, 8, 0};
  logic [1:0] crm [5] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h2};
  logic [1:0] ccm [5] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0};
  logic [3:0] cw [5] = '{4'h8, 4'h6, 4'h4, 4'h4, 4'h3};
  logic cexp [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  always #25 clk_sys = ~clk_sys;

  for (genvar p = 0; p < 2; p++) begin : gen_user
    ram_user_port usr (.clk_sys(clk_sys), .rst(rst), .req(req[p]), .req_we(req_we[p]), .hold(hold[p]),
      .req_addr(req_addr[p]), .req_din(req_din[p]), .req_be(req_be[p]), .tick(tick[p]), .ce(ce[p]),
      .addr(addr[p]), .din(din[p]), .be(be[p]), .we(we[p]), .re(re[p]));
  end

  embedded_ram_tile dut (.clk_sys(clk_sys), .rst(rst), .cfg_ram_mode(cfg_ram_mode),
    .cfg_clock_mode(cfg_clock_mode), .cfg_width_a(cfg_width), .cfg_width_b(cfg_width),
    .cfg_bypass_a(bypass[0]), .cfg_bypass_b(bypass[1]), .tick_a(tick[0]), .tick_b(tick[1]), .ce_a(ce[0]),
    .ce_b(ce[1]), .clr_a(clr[0]), .clr_b(clr[1]), .addr_a(addr[0]), .din_a(din[0]), .be_a(be[0]),
    .we_a(we[0]), .re_a(re[0]), .addr_b(addr[1]), .din_b(din[1]), .be_b(be[1]), .we_b(we[1]),
    .re_b(re[1]), .dout_a(dout[0]), .dout_b(dout[1]), .config_error(config_error));

  function automatic word_t merge(word_t old, word_t nw, logic [3:0] b, int wb, int lb);
    word_t r;
    r = '0;
    for (int j = 0; j < wb; j++) begin
      r[j] = (lb == 0 || b[j / lb]) ? nw[j] : old[j];
    end
    return r;
  endfunction

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_word(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected data at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected flag at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic [1:0] rm, input logic [1:0] cm, input logic [3:0] w, input logic by);
    @(posedge clk_sys);
    hold <= 2'h0;
    cfg_ram_mode <= rm;
    cfg_clock_mode <= cm;
    cfg_width <= w;
    bypass <= {by, by};
    repeat (3) @(posedge clk_sys);
  endtask

  // Waits well past the bypass and registered read latencies before returning.
  task automatic op(input int p, input logic w, input logic [11:0] a, input word_t d, input logic [3:0] b);
    @(posedge clk_sys);
    req[p] <= 1'b1;
    req_we[p] <= w;
    req_addr[p] <= a;
    req_din[p] <= d;
    req_be[p] <= b;
    @(posedge clk_sys);
    req[p] <= 1'b0;
    repeat (7) @(posedge clk_sys);
  endtask

  // The clock enable of the cleared clock stays low afterwards, or its output register
  // would reload the held read data on the next edge. The next cfg call releases it.
  task automatic pulse(input int p);
    @(posedge clk_sys);
    clr[p] <= 1'b1;
    hold[p] <= 1'b1;
    @(posedge clk_sys);
    clr[p] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int w = 0; w < 5; w++) begin
      cfg(2'h1, 2'h2, wt[w], w[0]);
      for (int b = 0; b < 16; b++) begin
        op(0, 1'b1, 12'(b), BASE, 4'hF);
        op(0, 1'b1, 12'(b), NEW, 4'(b));
        op(1, 1'b0, 12'(b), '0, 4'h0);
        chk_word(dout[1], merge(BASE, NEW, 4'(b), wbits[w], lbits[w]));
      end
    end
    pulse(1);
    chk_word(dout[1], '0);
    cfg(2'h0, 2'h0, 4'h4, 1'b0);
    op(0, 1'b1, 12'h007, 36'h000001234, 4'hF);
    hold[0] <= 1'b1;
    op(0, 1'b1, 12'h007, 36'h000005678, 4'hF);
    hold[0] <= 1'b0;
    op(0, 1'b0, 12'h007, '0, 4'h0);
    chk_word(dout[0], 36'h000001234);
    op(1, 1'b0, 12'h007, '0, 4'h0);
    chk_word(dout[1], 36'h000001234);
    pulse(0);
    chk_word(dout[0], '0);
    chk_word(dout[1], 36'h000001234);
    cfg(2'h0, 2'h1, 4'h4, 1'b0);
    op(0, 1'b0, 12'h007, '0, 4'h0);
    chk_word(dout[0], 36'h000001234);
    pulse(1);
    chk_word(dout[0], '0);
    chk_word(dout[1], 36'h000001234);
    pulse(0);
    chk_word(dout[1], '0);
    cfg(2'h2, 2'h0, 4'h3, 1'b1);
    op(0, 1'b1, 12'h003, 36'h00000003C, 4'hF);
    op(1, 1'b1, 12'h003, 36'h0000000C3, 4'hF);
    op(0, 1'b0, 12'h003, '0, 4'h0);
    chk_word(dout[0], 36'h00000003C);
    op(1, 1'b0, 12'h003, '0, 4'h0);
    chk_word(dout[1], 36'h0000000C3);
    for (int c = 0; c < 5; c++) begin
      cfg(crm[c], ccm[c], cw[c], 1'b0);
      chk_flag(config_error, cexp[c]);
    end
    stop_test();
  end

  initial begin
    repeat (10000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end
endmodule
